// file: verilog/meter_port_defs.vh
`ifndef METER_PORT_DEFS_VH
`define METER_PORT_DEFS_VH

// =====================================================================
// Serial port framing
`define SP_WORD_BITS        8
`define SP_CNT_W            3
`define SP_LAST_BIT         3'h7
// Buffer shape
`define SP_FIFO_DEPTH       8
`define SP_FIFO_AW          3
// Master clock nominal frequency in Hz (supplied by the board)
`define MASTER_CLK_HZ       3579545
// System clock period in ns
`define SYS_CLK_NS          10
// Sag watch: low-voltage duration in system cycles
`define SAG_CYCLES_DEF      16'h0100
// Zero-crossing watchdog in system cycles
`define ZX_TIMEOUT_DEF      24'h0F4240
// Interrupt source bit positions
`define IRQ_ROLL_BIT        0
`define IRQ_HALF_BIT        1
`define IRQ_SAMPLE_BIT      2
`define IRQ_NUM             3

`endif

// file: verilog/sp_fifo.v
`timescale 1ns/100ps
`default_nettype none

module sp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_sys_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_wr_data,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    output wire [WIDTH-1:0] o_rd_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_r;
    reg [AW:0]      rd_ptr_r;
    wire            full_w;
    wire            empty_w;

    // =================================================================
    // Flags
    assign empty_w    = (wr_ptr_r == rd_ptr_r);
    assign full_w     = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                        (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign o_wr_ready = ~full_w;
    assign o_rd_valid = ~empty_w;
    assign o_rd_data  = mem[rd_ptr_r[AW-1:0]];

    // Storage
    always @(posedge i_sys_clk) begin
        if (i_wr_valid && !full_w)
            mem[wr_ptr_r[AW-1:0]] <= i_wr_data;
    end

    // Pointers
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end else begin
            if (i_wr_valid && !full_w)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (i_rd_ready && !empty_w)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule

`default_nettype wire

// file: verilog/meter_serial_port.v
`timescale 1ns/100ps
`default_nettype none
`include "meter_port_defs.vh"

module meter_serial_port #(
    parameter WIDTH      = `SP_WORD_BITS,
    parameter DEPTH      = `SP_FIFO_DEPTH,
    parameter AW         = `SP_FIFO_AW,
    parameter SAG_CYC    = `SAG_CYCLES_DEF,
    parameter ZX_TIMEOUT = `ZX_TIMEOUT_DEF
) (
    input  wire             i_sys_clk,
    input  wire             i_rst_n,
    input  wire             i_cs_n,
    input  wire             i_sclk,
    input  wire             i_din,
    output reg              o_dout,
    output reg              o_dout_oe,
    input  wire [WIDTH-1:0] i_tx_data,
    input  wire             i_tx_valid,
    output reg              o_tx_ready,
    output reg  [WIDTH-1:0] o_rx_data,
    output reg              o_rx_valid,
    input  wire             i_rx_ready,
    input  wire             i_vsign,
    input  wire             i_vlow,
    input  wire [2:0]       i_irq_event,
    input  wire [2:0]       i_irq_mask,
    input  wire [2:0]       i_irq_clear,
    output reg              o_zero_cross_out,
    output reg              o_sag_out,
    output reg              o_sag_oe,
    output reg              o_irq_out,
    output reg              o_irq_oe
);
    // =================================================================
    // Pin synchronisers
    reg  [1:0] cs_sync_r;
    reg  [1:0] sclk_sync_r;
    reg  [1:0] din_sync_r;
    reg  [1:0] vs_sync_r;
    reg  [1:0] vl_sync_r;
    reg        sclk_d_r;
    reg        vsign_d_r;
    wire       cs_act_w;
    wire       sclk_rise_w;
    wire       sclk_fall_w;

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_sync_r   <= 2'h3;
            sclk_sync_r <= 2'h0;
            din_sync_r  <= 2'h0;
            vs_sync_r   <= 2'h0;
            vl_sync_r   <= 2'h0;
            sclk_d_r    <= 1'b0;
            vsign_d_r   <= 1'b0;
        end else begin
            cs_sync_r   <= {cs_sync_r[0], i_cs_n};
            sclk_sync_r <= {sclk_sync_r[0], i_sclk};
            din_sync_r  <= {din_sync_r[0], i_din};
            vs_sync_r   <= {vs_sync_r[0], i_vsign};
            vl_sync_r   <= {vl_sync_r[0], i_vlow};
            sclk_d_r    <= sclk_sync_r[1];
            vsign_d_r   <= vs_sync_r[1];
        end
    end

    assign cs_act_w    = ~cs_sync_r[1];
    assign sclk_rise_w = cs_act_w & sclk_sync_r[1] & ~sclk_d_r;
    assign sclk_fall_w = cs_act_w & ~sclk_sync_r[1] & sclk_d_r;

    // =================================================================
    // Transmit buffer
    wire [WIDTH-1:0] txq_data_w;
    wire             txq_valid_w;
    wire             txq_wr_ready_w;
    reg              tx_load_w;

    sp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_wr_data  (i_tx_data),
        .i_wr_valid (i_tx_valid),
        .o_wr_ready (txq_wr_ready_w),
        .o_rd_data  (txq_data_w),
        .o_rd_valid (txq_valid_w),
        .i_rd_ready (tx_load_w)
    );

    // =================================================================
    // Shift engine
    // Bits move only on detected link clock edges with select low
    reg [WIDTH-1:0]      tx_sh_r;
    reg [WIDTH-1:0]      rx_sh_r;
    reg [`SP_CNT_W-1:0]  rx_cnt_r;
    reg [`SP_CNT_W-1:0]  tx_cnt_r;
    reg                  tx_busy_r;
    wire                 tx_last_w;
    wire                 rx_last_w;
    wire [WIDTH-1:0]     rx_word_w;

    // Word fetch on first rising edge of a word
    always @* begin
        tx_load_w = sclk_rise_w & ~tx_busy_r & txq_valid_w;
    end

    // Last-bit decodes and the word being completed
    assign tx_last_w = (tx_cnt_r == `SP_LAST_BIT);
    assign rx_last_w = (rx_cnt_r == `SP_LAST_BIT);
    assign rx_word_w = {rx_sh_r[WIDTH-2:0], din_sync_r[1]};

    // =================================================================
    // Transmit side
    // Buffer space flag, one cycle behind the buffer
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= txq_wr_ready_w;
        end
    end

    // Bit counter and busy flag; a deselect drops the word
    // A word cut short is lost, the host must fetch it again
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_cnt_r  <= {`SP_CNT_W{1'b0}};
            tx_busy_r <= 1'b0;
        end else if (!cs_act_w) begin
            tx_cnt_r  <= {`SP_CNT_W{1'b0}};
            tx_busy_r <= 1'b0;
        end else if (tx_load_w) begin
            tx_cnt_r  <= {`SP_CNT_W{1'b0}};
            tx_busy_r <= 1'b1;
        end else if (sclk_rise_w && tx_busy_r) begin
            if (tx_last_w) begin
                tx_busy_r <= 1'b0;
            end else begin
                tx_cnt_r <= tx_cnt_r + 1'b1;
            end
        end
    end

    // Shifter and data pin, most significant bit first
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_sh_r <= {WIDTH{1'b0}};
            o_dout  <= 1'b0;
        end else if (tx_load_w) begin
            o_dout  <= txq_data_w[WIDTH-1];
            tx_sh_r <= {txq_data_w[WIDTH-2:0], 1'b0};
        end else if (sclk_rise_w && tx_busy_r && !tx_last_w) begin
            o_dout  <= tx_sh_r[WIDTH-1];
            tx_sh_r <= {tx_sh_r[WIDTH-2:0], 1'b0};
        end
    end

    // Pin enable: on at the first bit, off after the last or on deselect
    // The rising edge after the last bit ends the drive
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dout_oe <= 1'b0;
        end else if (!cs_act_w) begin
            o_dout_oe <= 1'b0;
        end else if (tx_load_w) begin
            o_dout_oe <= 1'b1;
        end else if (sclk_rise_w && tx_busy_r && tx_last_w) begin
            o_dout_oe <= 1'b0;
        end
    end

    // =================================================================
    // Receive side
    // Shifter and bit counter; a deselect restarts the word
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_sh_r  <= {WIDTH{1'b0}};
            rx_cnt_r <= {`SP_CNT_W{1'b0}};
        end else if (!cs_act_w) begin
            rx_cnt_r <= {`SP_CNT_W{1'b0}};
        end else if (sclk_fall_w) begin
            rx_sh_r  <= rx_word_w;
            rx_cnt_r <= rx_cnt_r + 1'b1;
        end
    end

    // Word handover; a word not taken in time is overwritten
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_data  <= {WIDTH{1'b0}};
            o_rx_valid <= 1'b0;
        end else if (sclk_fall_w && rx_last_w) begin
            o_rx_data  <= rx_word_w;
            o_rx_valid <= 1'b1;
        end else if (o_rx_valid && i_rx_ready) begin
            o_rx_valid <= 1'b0;
        end
    end

    // =================================================================
    // Zero crossing and sag watch
    reg [23:0] zx_wd_r;
    reg [15:0] low_cnt_r;
    wire       vs_edge_w;
    wire       zx_lost_w;
    wire       low_long_w;

    // Sign change, lost crossings and long low level
    assign vs_edge_w  = (vs_sync_r[1] != vsign_d_r);
    assign zx_lost_w  = (zx_wd_r == ZX_TIMEOUT[23:0]);
    assign low_long_w = (low_cnt_r == SAG_CYC[15:0]);

    // Output level flips on every sign change
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_zero_cross_out <= 1'b0;
        end else if (vs_edge_w) begin
            o_zero_cross_out <= ~o_zero_cross_out;
        end
    end

    // Cycles since the last crossing, saturating
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zx_wd_r <= 24'h000000;
        end else if (vs_edge_w) begin
            zx_wd_r <= 24'h000000;
        end else if (!zx_lost_w) begin
            zx_wd_r <= zx_wd_r + 24'h000001;
        end
    end

    // Length of the present low-voltage run, saturating
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_r <= 16'h0000;
        end else if (!vl_sync_r[1]) begin
            low_cnt_r <= 16'h0000;
        end else if (!low_long_w) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end

    // Open-drain sag pin: level stays low, the enable pulls it
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sag_out <= 1'b0;
            o_sag_oe  <= 1'b0;
        end else begin
            o_sag_out <= 1'b0;
            o_sag_oe  <= zx_lost_w || low_long_w;
        end
    end

    // =================================================================
    // Interrupt pending bits, one flop per source
    wire [`IRQ_NUM-1:0] irq_pend_w;
    genvar              g;

    generate
        for (g = 0; g < `IRQ_NUM; g = g + 1) begin : g_irq
            reg pend_r;

            // A new event wins over a clear in the same cycle
            always @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pend_r <= 1'b0;
                end else if (i_irq_event[g]) begin
                    pend_r <= 1'b1;
                end else if (i_irq_clear[g]) begin
                    pend_r <= 1'b0;
                end
            end

            // Pending bit into the shared vector
            assign irq_pend_w[g] = pend_r;
        end
    endgenerate

    // Open-drain request pin: pulls low while an enabled bit is set
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_out <= 1'b0;
            o_irq_oe  <= 1'b0;
        end else begin
            o_irq_out <= 1'b0;
            o_irq_oe  <= |(irq_pend_w & i_irq_mask);
        end
    end
endmodule

`default_nettype wire

// file: bench/meter_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Pin-level checker for the serial port
module meter_port_sva #(parameter SAG_CYC = 16) (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_cs_n,
    input wire logic       i_vsign,
    input wire logic       i_vlow,
    input wire logic [2:0] i_irq_event,
    input wire logic [2:0] i_irq_mask,
    input wire logic       o_dout_oe,
    input wire logic       o_zero_cross_out,
    input wire logic       o_sag_out,
    input wire logic       o_sag_oe,
    input wire logic       o_irq_out,
    input wire logic       o_irq_oe
);
    int low_cnt_r;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Length of the current low-voltage run
    always @(posedge i_sys_clk or negedge i_rst_n)
        if (!i_rst_n)
            low_cnt_r <= 0;
        else
            low_cnt_r <= i_vlow ? low_cnt_r + 1 : 0;
    // ========================================
    // Pin relations
    a_dout_idle: assert property (i_cs_n [*5] |-> !o_dout_oe)
        else $error("dout enabled while deselected");
    a_cs_abort: assert property ($rose(i_cs_n) |-> ##[1:4] !o_dout_oe)
        else $error("dout kept after deselect");
    a_oe_select:
        assert property ($rose(o_dout_oe) |-> $past(!i_cs_n, 3))
        else $error("dout enabled without select");
    a_sag_pin: assert property (o_sag_out == 1'b0)
        else $error("sag pin driven high");
    a_sag_low: assert property (low_cnt_r > SAG_CYC + 6 |-> o_sag_oe)
        else $error("sag not raised on low voltage");
    a_irq_pin: assert property (o_irq_out == 1'b0)
        else $error("irq pin driven high");
    a_irq_raise:
        assert property (|(i_irq_event & i_irq_mask) |-> ##[1:3] o_irq_oe)
        else $error("enabled event gave no irq");
    a_zx_follow:
        assert property ($changed(i_vsign) |->
            ##[2:5] $changed(o_zero_cross_out))
        else $error("zero cross did not toggle");
    c_frame: cover property ($fell(o_dout_oe));
    c_irq: cover property ($rose(o_irq_oe));
    c_sag: cover property ($rose(o_sag_oe));
endmodule

bind meter_serial_port meter_port_sva #(.SAG_CYC(SAG_CYC))
    i_meter_port_sva (.*);
`default_nettype wire

// file: bench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Serial bus master model, 80 ns link clock
module spi_host_model (
    output var logic o_cs_n,
    output var logic o_sclk,
    output var logic o_din,
    input wire logic i_dout,
    input wire logic i_dout_oe
);
    logic held_r;
    wire  line = i_dout_oe ? i_dout : ~held_r;
    // Released line shows the inverse of its last level
    always @(i_dout or i_dout_oe)
        if (i_dout_oe)
            held_r = i_dout;
    // Idle: deselected, clock still
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    // One frame of n bits, MSB first; n below 8 aborts it
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        #3.3 o_cs_n = 1'b0;
        #40;
        for (int i = 7; i > 7 - n; i--) begin
            o_sclk = 1'b1;
            o_din = tx[i];
            #40 o_sclk = 1'b0;
            #37 rx[i] = line;
            #3;
        end
        #40 o_cs_n = 1'b1;
        o_din = ~o_din;
    endtask
endmodule
`default_nettype wire

// file: bench/test_meter_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Bench for the meter serial port
module test_meter_serial_port;
    logic       i_sys_clk, i_rst_n, i_cs_n, i_sclk, i_din, o_dout;
    logic       o_dout_oe, i_tx_valid, o_tx_ready, o_rx_valid, i_rx_ready;
    logic       i_vsign, i_vlow, o_zero_cross_out, o_sag_out, o_sag_oe;
    logic       o_irq_out, o_irq_oe;
    logic [7:0] i_tx_data, o_rx_data, rxw;
    logic [2:0] i_irq_event, i_irq_mask, i_irq_clear;
    int         fail_count, cmp_count;
    wire  [7:0] rst_outs = {o_dout_oe, o_tx_ready, o_sag_oe, o_irq_oe, 4'h0};

    meter_serial_port #(.SAG_CYC(16), .ZX_TIMEOUT(64))
        i_meter_serial_port (.*);
    spi_host_model i_spi_host_model (.o_cs_n(i_cs_n), .o_sclk(i_sclk),
        .o_din(i_din), .i_dout(o_dout), .i_dout_oe(o_dout_oe));
    // Clock and hang guard
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #100us;
        fail_count++;
        stop_test;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic chk(input string name, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One full frame; the device must receive what was sent
    task automatic frame(input logic [7:0] w);
        i_spi_host_model.xfer(w, 8, rxw);
        cyc(6);
        chk("rx_data", w, o_rx_data);
        chk("rx_valid", 8'h01, 8'(o_rx_valid));
        chk("dout_oe", 8'h00, 8'(o_dout_oe));
        i_rx_ready <= 1'b1;
        cyc(1);
        i_rx_ready <= 1'b0;
    endtask
    // Fill the buffer until refused, then drain it over the link
    task automatic t_fifo;
        int n;
        n = 0;
        while (o_tx_ready === 1'b1 && n < 12) begin
            i_tx_data <= 8'hA0 + 8'(n);
            i_tx_valid <= 1'b1;
            cyc(1);
            i_tx_valid <= 1'b0;
            cyc(2);
            n++;
        end
        chk("depth", 8'h08, 8'(n));
        for (int i = 0; i < 8; i++) begin
            frame(8'h3C ^ 8'(i));
            chk("tx word", 8'hA0 + 8'(i), rxw);
        end
        chk("tx_ready", 8'h01, 8'(o_tx_ready));
    endtask
    // Frame cut short by deselect, then a clean one
    task automatic t_abort;
        i_tx_data <= 8'h5A;
        i_tx_valid <= 1'b1;
        cyc(1);
        i_tx_valid <= 1'b0;
        cyc(3);
        i_spi_host_model.xfer(8'hFF, 3, rxw);
        cyc(10);
        chk("abort rx", 8'h00, 8'(o_rx_valid));
        chk("abort oe", 8'h00, 8'(o_dout_oe));
        chk("abort tx", 8'h40, rxw & 8'hE0);
        frame(8'h96);
    endtask
    // Each source raised and cleared, then all masked
    task automatic t_irq;
        for (int b = 0; b < 3; b++) begin
            i_irq_mask <= 3'h1 << b;
            i_irq_event <= 3'h1 << b;
            cyc(1);
            i_irq_event <= 3'h0;
            cyc(3);
            chk("irq set", 8'h01, 8'(o_irq_oe));
            i_irq_clear <= 3'h7;
            cyc(1);
            i_irq_clear <= 3'h0;
            cyc(3);
            chk("irq clear", 8'h00, 8'(o_irq_oe));
        end
        i_irq_mask <= 3'h0;
        i_irq_event <= 3'h7;
        cyc(1);
        i_irq_event <= 3'h0;
        cyc(4);
        chk("irq masked", 8'h00, 8'(o_irq_oe));
        i_irq_clear <= 3'h7;
        cyc(1);
        i_irq_clear <= 3'h0;
    endtask
    // Zero crossings toggle, then missing crossings and low voltage
    task automatic t_zx;
        logic z;
        z = 1'b0;
        for (int i = 0; i < 6; i++) begin
            i_vsign <= ~i_vsign;
            z = ~z;
            cyc(20);
            chk("zero cross", 8'(z), 8'(o_zero_cross_out));
        end
        cyc(100);
        chk("sag", 8'h01, 8'(o_sag_oe));
        i_vsign <= ~i_vsign;
        cyc(10);
        chk("sag clear", 8'h00, 8'(o_sag_oe));
        i_vlow <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            i_vsign <= ~i_vsign;
            cyc(10);
        end
        chk("sag low", 8'h01, 8'(o_sag_oe));
        i_vlow <= 1'b0;
    endtask
    // Main sequence
    initial begin
        {i_rst_n, i_tx_valid, i_rx_ready, i_vsign, i_vlow} = 5'h00;
        {i_irq_event, i_irq_mask, i_irq_clear} = 9'h000;
        i_tx_data = 8'h00;
        fail_count = 0;
        cmp_count = 0;
        cyc(8);
        chk("reset", 8'h00, rst_outs);
        cyc(8);
        i_rst_n <= 1'b1;
        cyc(4);
        t_fifo;
        t_abort;
        t_irq;
        t_zx;
        stop_test;
    end
endmodule
`default_nettype wire
